//--- common/eia9_pkg.sv
// Purpose: constants and carriers for the group nine interrupt aggregator
// Assumes: Avalon-MM slave, 8-bit registers in the low byte of 32-bit words
// Notes: printed offsets are not multiples of four, so each is an index
package eia9_pkg;
	localparam logic [15:0] EIA9_IDX_FLAGS = 16'h2848;
	localparam logic [15:0] EIA9_IDX_INTYPE = 16'h2849;
	localparam logic [15:0] EIA9_IDX_OUTTYPE = 16'h284A;
	localparam logic [15:0] EIA9_IDX_ENABLES = 16'h284B;
	localparam logic [15:0] EIA9_IDX_OVERRUN = 16'h284C;
	localparam logic [15:0] EIA9_IDX_PCTRL = 16'h2D01;
	localparam logic [15:0] EIA9_IDX_CORE = 16'h2D10;
	localparam logic [7:0] EIA9_SRC_MASK = 8'hEC;
	localparam logic [7:0] EIA9_RST_FLAGS = 8'h00;
	localparam logic [7:0] EIA9_RST_INTYPE = 8'hEC;
	localparam logic [7:0] EIA9_RST_OUTTYPE = 8'h01;
	localparam logic [7:0] EIA9_RST_ENABLES = 8'h00;
	localparam logic [7:0] EIA9_RST_OVERRUN = 8'h00;
	localparam logic [7:0] EIA9_RST_PCTRL = 8'h00;
	localparam logic [7:0] EIA9_RST_CORE = 8'h00;
	localparam int EIA9_BIT_TX = 2;
	localparam int EIA9_BIT_RX = 3;
	localparam int EIA9_BIT_BAUD = 5;
	localparam int EIA9_BIT_PPS = 6;
	localparam int EIA9_BIT_ENERGY = 7;
	localparam int EIA9_BIT_GATE = 1;
	localparam int EIA9_BIT_FLAG = 5;
	localparam int EIA9_BIT_EXTEN = 1;
	localparam int EIA9_BIT_GLOBAL = 7;
	localparam logic [7:0] EIA9_VECTOR = 8'h4B;

	typedef enum logic [1:0] {
		EIA9_IDLE,
		EIA9_ANSWER
	} eia9_phase_t;

	typedef struct packed {
		eia9_phase_t phase;
		logic waitreq;
		logic [31:0] rdata;
		logic [7:0] flags;
		logic [7:0] intype;
		logic [7:0] outtype;
		logic [7:0] enables;
		logic [7:0] overrun;
		logic [7:0] pctrl;
		logic [7:0] core;
		logic irq;
		logic [7:0] ev_s1;
		logic [7:0] ev_s2;
		logic [7:0] ev_prev;
	} eia9_state_t;
endpackage : eia9_pkg

//--- dv/eia9_aggregator_test.sv
// Purpose: self-checking bench for the group nine aggregator
// Assumes: core mirror at 0x2D10 holds global and ext enables
// Notes: event pulses last two cycles, results are read eight cycles on
`timescale 1ns/1ps
module eia9_aggregator_test import eia9_pkg::*;;
	logic clk_sys, reset, avs_read, avs_write, avs_waitrequest, group9_irq, ok;
	logic [15:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rng;
	logic [3:0] avs_byteenable;
	logic [7:0] ev_bus, group9_vector, q, m, en;
	int n_errors, n_tests;
	localparam logic [15:0] RADR [8] = '{EIA9_IDX_FLAGS, EIA9_IDX_INTYPE, EIA9_IDX_OUTTYPE,
		EIA9_IDX_ENABLES, EIA9_IDX_OVERRUN, EIA9_IDX_PCTRL, EIA9_IDX_CORE, 16'h2D11};
	localparam logic [7:0] RVAL [8] = '{EIA9_RST_FLAGS, EIA9_RST_INTYPE, EIA9_RST_OUTTYPE,
		EIA9_RST_ENABLES, EIA9_RST_OVERRUN, EIA9_RST_PCTRL, EIA9_RST_CORE, 8'h00};
	localparam int SRC [5] = '{EIA9_BIT_TX, EIA9_BIT_RX, EIA9_BIT_BAUD, EIA9_BIT_PPS,
		EIA9_BIT_ENERGY};
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	eia9_aggregator uut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ev_serial_tx(ev_bus[2]), .ev_serial_rx(ev_bus[3]),
		.ev_serial_baud(ev_bus[5]), .ev_rtc_pps(ev_bus[6]), .ev_energy_pulse(ev_bus[7]),
		.group9_irq(group9_irq), .group9_vector(group9_vector));
	eia9_core_model core (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	// ***************************************************************
	// Expectations and helpers
	// ***************************************************************
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	function automatic logic [7:0] exp_flags(input logic [7:0] ev, input logic [7:0] e);
		return ev & e & EIA9_SRC_MASK;
	endfunction : exp_flags
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
		core.access(a, w, d, q, ok);
		chk("bus answer", 8'h01, {7'h00, ok});
	endtask : acc
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		acc(a, 1'b0, 8'h00);
		chk("register", exp, q);
	endtask : rd
	task automatic irq_is(input logic exp);
		repeat (6) @(posedge clk_sys);
		chk("irq", {7'h00, exp}, {7'h00, group9_irq});
	endtask : irq_is
	// Firing the other sources in the same pulse exercises the enable gating
	task automatic fire(input logic [7:0] mk);
		@(posedge clk_sys);
		ev_bus <= mk;
		repeat (2) @(posedge clk_sys);
		ev_bus <= 8'h00;
		repeat (6) @(posedge clk_sys);
	endtask : fire
	task automatic results;
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_errors++;
		results();
	end
	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		reset = 1'b1;
		ev_bus = 8'h00;
		n_errors = 0;
		n_tests = 0;
		rng = 32'h00003BA6;
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 8; i++) rd(RADR[i], RVAL[i]);
		chk("vector", EIA9_VECTOR, group9_vector);
		acc(EIA9_IDX_CORE, 1'b1, 8'h82);
		acc(EIA9_IDX_PCTRL, 1'b1, 8'h02);
		foreach (SRC[i]) begin
			m = 8'h01 << SRC[i];
			acc(EIA9_IDX_ENABLES, 1'b1, m);
			fire(EIA9_SRC_MASK);
			rd(EIA9_IDX_FLAGS, m);
			irq_is(1'b1);
			rd(EIA9_IDX_CORE, 8'hA2);
			fire(EIA9_SRC_MASK);
			rd(EIA9_IDX_OVERRUN, m);
			acc(EIA9_IDX_FLAGS, 1'b1, 8'h00);
			irq_is(1'b0);
			rd(EIA9_IDX_OVERRUN, m);
			acc(EIA9_IDX_OVERRUN, 1'b1, 8'h00);
			rd(EIA9_IDX_OVERRUN, 8'h00);
		end
		acc(EIA9_IDX_ENABLES, 1'b1, 8'h00);
		acc(EIA9_IDX_FLAGS, 1'b1, 8'hFF);
		rd(EIA9_IDX_FLAGS, 8'h00);
		acc(EIA9_IDX_ENABLES, 1'b1, 8'hFF);
		acc(EIA9_IDX_FLAGS, 1'b1, 8'hFF);
		rd(EIA9_IDX_FLAGS, EIA9_SRC_MASK);
		irq_is(1'b1);
		acc(EIA9_IDX_PCTRL, 1'b1, 8'h00);
		irq_is(1'b0);
		acc(EIA9_IDX_PCTRL, 1'b1, 8'h02);
		acc(EIA9_IDX_CORE, 1'b1, 8'h02);
		irq_is(1'b0);
		acc(EIA9_IDX_CORE, 1'b1, 8'h80);
		irq_is(1'b0);
		acc(EIA9_IDX_CORE, 1'b1, 8'h82);
		acc(EIA9_IDX_INTYPE, 1'b1, 8'h00);
		rd(EIA9_IDX_INTYPE, EIA9_RST_INTYPE);
		for (int i = 0; i < 40; i++) begin
			rng = xorshift(rng);
			en = rng[7:0];
			acc(EIA9_IDX_FLAGS, 1'b1, 8'h00);
			acc(EIA9_IDX_ENABLES, 1'b1, en);
			fire(rng[15:8]);
			rd(EIA9_IDX_FLAGS, exp_flags(rng[15:8], en));
			chk("irq", {7'h00, |exp_flags(rng[15:8], en)}, {7'h00, group9_irq});
		end
		// Dirty flags and pending bits, then reset in mid-run
		acc(EIA9_IDX_ENABLES, 1'b1, 8'hFF);
		acc(EIA9_IDX_FLAGS, 1'b1, 8'hFF);
		fire(EIA9_SRC_MASK);
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 8; i++) rd(RADR[i], RVAL[i]);
		chk("irq", 8'h00, {7'h00, group9_irq});
		results();
	end
endmodule : eia9_aggregator_test

//--- dv/eia9_core_model.sv
// Purpose: core-side master that reaches the aggregator registers
// Assumes: one transfer at a time, started by the bench
// Notes: the type registers only ever receive their reset values
`timescale 1ns/1ps
module eia9_core_model import eia9_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Avalon-MM master
	output logic [15:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 16'h0000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
	end
	// ***************************************************************
	// One bus cycle; the answer is taken at the edge that sees waitrequest low
	// ***************************************************************
	task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		int n;
		logic [7:0] v;
		v = d;
		if (a === EIA9_IDX_INTYPE) v = EIA9_RST_INTYPE;
		if (a === EIA9_IDX_OUTTYPE) v = EIA9_RST_OUTTYPE;
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= {24'h000000, v};
		avs_byteenable <= 4'hF;
		n = 0;
		ok = 1'b0;
		while (!ok && n < 100) begin
			@(posedge clk_sys);
			n++;
			ok = (avs_waitrequest === 1'b0);
		end
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Released lines carry junk, never the last value
		avs_address <= ~a;
		avs_writedata <= ~{24'h000000, v};
		avs_byteenable <= 4'h0;
	endtask : access
endmodule : eia9_core_model

//--- hdl/eia9_aggregator.sv
// Purpose: merges five peripheral events into the shared interrupt nine request
// Assumes: event inputs are asynchronous levels; each rising edge is one event
// Notes: core-side flag and enable bits are mirrored in a local register at 0x2D10
//
// Operation
// - Five events merge into one request, served at vector 4Bh.
// - Requests pass only when peripheral control bit 1 is set.
// - Request shows in core flag bit 5; taken with global and ext enables.
// - Serial port five transmit event uses flag and enable bit 2.
// - Serial port five receive event uses flag and enable bit 3.
// - Serial port five baud timer overflow uses bit 5.
// - Clock once-per-second pulse uses bit 6.
// - Second path energy pulse uses bit 7.
// - Flag reads 1 after a request, 0 otherwise.
// - A flag sets only while its source enable is set.
// - Writing 1 to a flag raises it only when enabled.
// - Writing 0 to a flag clears it.
// - Enable bit 1 enables source, 0 disables; unused bits ignored.
// - Implemented flags read 0 after reset.
// - Pending bit sets when source fires again before flag cleared.
// - Pending bits never affect request or delivery.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module eia9_aggregator import eia9_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Peripheral events
	input wire logic ev_serial_tx,
	input wire logic ev_serial_rx,
	input wire logic ev_serial_baud,
	input wire logic ev_rtc_pps,
	input wire logic ev_energy_pulse,
	// Toward the core
	output logic group9_irq,
	output logic [7:0] group9_vector
);
	// ****************************************************************
	// State
	// ****************************************************************
	eia9_state_t s_reg;
	eia9_state_t s_next;
	logic [7:0] ev_raw;
	logic [7:0] ev_rise;
	logic [7:0] hw_set;
	logic [7:0] wbyte;
	logic wr_hit;
	logic rd_hit;

	assign ev_raw = {ev_energy_pulse, ev_rtc_pps, ev_serial_baud, 1'b0,
		ev_serial_rx, ev_serial_tx, 2'b00};
	assign wbyte = avs_writedata[7:0];

	function automatic logic [7:0] eia9_read(input eia9_state_t s, input logic [15:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == EIA9_IDX_FLAGS) begin
			v = s.flags & EIA9_SRC_MASK;
		end else if (a == EIA9_IDX_INTYPE) begin
			v = s.intype;
		end else if (a == EIA9_IDX_OUTTYPE) begin
			v = s.outtype;
		end else if (a == EIA9_IDX_ENABLES) begin
			v = s.enables;
		end else if (a == EIA9_IDX_OVERRUN) begin
			v = s.overrun;
		end else if (a == EIA9_IDX_PCTRL) begin
			v = s.pctrl;
		end else if (a == EIA9_IDX_CORE) begin
			v = s.core;
		end
		return v;
	endfunction : eia9_read

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		s_next = s_reg;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		// Synchronise event levels; only the second stage feeds edge logic
		s_next.ev_s1 = ev_raw;
		s_next.ev_s2 = s_reg.ev_s1;
		s_next.ev_prev = s_reg.ev_s2;
		ev_rise = s_reg.ev_s2 & ~s_reg.ev_prev & EIA9_SRC_MASK;
		hw_set = ev_rise & s_reg.enables;
		case (s_reg.phase)
			EIA9_IDLE: begin
				if (avs_write || avs_read) begin
					s_next.phase = EIA9_ANSWER;
				end
				// Fetch on entry so data already stand while waitrequest is low;
				// a flag set during the answer cycle shows on the next read
				rd_hit = avs_read;
			end
			EIA9_ANSWER: begin
				s_next.phase = EIA9_IDLE;
				wr_hit = avs_write && avs_byteenable[0];
			end
			default: s_next.phase = EIA9_IDLE;
		endcase
		// Registered so the bus sees waitrequest straight from a flip-flop
		s_next.waitreq = (s_next.phase != EIA9_ANSWER);
		if (rd_hit) begin
			s_next.rdata = {24'h000000, eia9_read(s_reg, avs_address)};
		end
		if (wr_hit) begin
			if (avs_address == EIA9_IDX_FLAGS) begin
				// Ones set only enabled bits, zeros clear
				s_next.flags = wbyte & s_reg.flags;
				s_next.flags = s_next.flags | (wbyte & s_reg.enables & EIA9_SRC_MASK);
			end else if (avs_address == EIA9_IDX_INTYPE) begin
				s_next.intype = wbyte;
			end else if (avs_address == EIA9_IDX_OUTTYPE) begin
				s_next.outtype = wbyte;
			end else if (avs_address == EIA9_IDX_ENABLES) begin
				s_next.enables = wbyte & EIA9_SRC_MASK;
			end else if (avs_address == EIA9_IDX_OVERRUN) begin
				s_next.overrun = wbyte & s_reg.overrun;
			end else if (avs_address == EIA9_IDX_PCTRL) begin
				s_next.pctrl = wbyte;
			end else if (avs_address == EIA9_IDX_CORE) begin
				s_next.core = wbyte;
			end
		end
		// Hardware set wins over a software clear in the same cycle
		s_next.overrun = s_next.overrun | (hw_set & s_reg.flags);
		s_next.flags = s_next.flags | hw_set;
		// Core flag bit mirrors the gated group request
		s_next.core[EIA9_BIT_FLAG] = s_reg.pctrl[EIA9_BIT_GATE]
			&& ((s_reg.flags & s_reg.enables & EIA9_SRC_MASK) != 8'h00);
		s_next.irq = s_reg.core[EIA9_BIT_FLAG] && s_reg.core[EIA9_BIT_GLOBAL]
			&& s_reg.core[EIA9_BIT_EXTEN];
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_reg.phase <= EIA9_IDLE;
			s_reg.waitreq <= 1'b1;
			s_reg.rdata <= 32'h00000000;
			s_reg.flags <= EIA9_RST_FLAGS;
			s_reg.intype <= EIA9_RST_INTYPE;
			s_reg.outtype <= EIA9_RST_OUTTYPE;
			s_reg.enables <= EIA9_RST_ENABLES;
			s_reg.overrun <= EIA9_RST_OVERRUN;
			s_reg.pctrl <= EIA9_RST_PCTRL;
			s_reg.core <= EIA9_RST_CORE;
			s_reg.irq <= 1'b0;
			s_reg.ev_s1 <= 8'h00;
			s_reg.ev_s2 <= 8'h00;
			s_reg.ev_prev <= 8'h00;
		end else begin
			s_reg <= s_next;
		end
	end

	// Answer phase holds waitrequest low for exactly one cycle
	assign avs_waitrequest = s_reg.waitreq;
	assign avs_readdata = s_reg.rdata;
	assign group9_irq = s_reg.irq;
	assign group9_vector = EIA9_VECTOR;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_gate;
		@(posedge clk_sys) disable iff (reset)
		!s_reg.pctrl[EIA9_BIT_GATE] |=> !s_reg.core[EIA9_BIT_FLAG];
	endproperty
	a_gate: assert property (p_gate) else $error("request passed with gate off");

	property p_take;
		@(posedge clk_sys) disable iff (reset)
		group9_irq |-> $past(s_reg.core[EIA9_BIT_GLOBAL]) && $past(s_reg.core[EIA9_BIT_EXTEN]);
	endproperty
	a_take: assert property (p_take) else $error("irq without core enables");

	property p_any;
		@(posedge clk_sys) disable iff (reset)
		(s_reg.pctrl[EIA9_BIT_GATE] && (s_reg.flags & s_reg.enables) != 8'h00)
		|=> s_reg.core[EIA9_BIT_FLAG];
	endproperty
	a_any: assert property (p_any) else $error("group request missing");

	property p_disabled;
		@(posedge clk_sys) disable iff (reset)
		(!s_reg.enables[EIA9_BIT_TX] && !s_reg.flags[EIA9_BIT_TX]) |=> !s_reg.flags[EIA9_BIT_TX];
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled flag set");

	property p_event;
		@(posedge clk_sys) disable iff (reset)
		$rose(s_reg.ev_s2[EIA9_BIT_ENERGY]) && s_reg.enables[EIA9_BIT_ENERGY] ##1 1'b1
		|-> s_reg.flags[EIA9_BIT_ENERGY];
	endproperty
	a_event: assert property (p_event) else $error("energy event lost");

	property p_overrun;
		@(posedge clk_sys) disable iff (reset)
		(hw_set[EIA9_BIT_RX] && s_reg.flags[EIA9_BIT_RX]) |=> s_reg.overrun[EIA9_BIT_RX];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not recorded");

	property p_keep_ovr;
		@(posedge clk_sys) disable iff (reset)
		(s_reg.overrun[EIA9_BIT_PPS] && !wr_hit) |=> s_reg.overrun[EIA9_BIT_PPS];
	endproperty
	a_keep_ovr: assert property (p_keep_ovr) else $error("pending cleared by itself");

	property p_clear;
		@(posedge clk_sys) disable iff (reset)
		(wr_hit && avs_address == EIA9_IDX_FLAGS && !wbyte[EIA9_BIT_BAUD]
			&& !hw_set[EIA9_BIT_BAUD]) |=> !s_reg.flags[EIA9_BIT_BAUD];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared by zero");

	property p_soft_set;
		@(posedge clk_sys) disable iff (reset)
		(wr_hit && avs_address == EIA9_IDX_FLAGS && wbyte[EIA9_BIT_RX]
			&& s_reg.enables[EIA9_BIT_RX]) |=> s_reg.flags[EIA9_BIT_RX];
	endproperty
	a_soft_set: assert property (p_soft_set) else $error("software set failed");

	property p_wait;
		@(posedge clk_sys) disable iff (reset)
		(avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");

	property p_tx_flag;
		@(posedge clk_sys) disable iff (reset)
		(ev_rise[EIA9_BIT_TX] && s_reg.enables[EIA9_BIT_TX])
			|=> s_reg.flags[EIA9_BIT_TX];
	endproperty
	a_tx_flag: assert property (p_tx_flag) else $error("transmit event lost");

	property p_rx_flag;
		@(posedge clk_sys) disable iff (reset)
		(ev_rise[EIA9_BIT_RX] && s_reg.enables[EIA9_BIT_RX])
			|=> s_reg.flags[EIA9_BIT_RX];
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive event lost");

	property p_baud_flag;
		@(posedge clk_sys) disable iff (reset)
		(ev_rise[EIA9_BIT_BAUD] && s_reg.enables[EIA9_BIT_BAUD])
			|=> s_reg.flags[EIA9_BIT_BAUD];
	endproperty
	a_baud_flag: assert property (p_baud_flag) else $error("baud overflow event lost");

	property p_pps_flag;
		@(posedge clk_sys) disable iff (reset)
		(ev_rise[EIA9_BIT_PPS] && s_reg.enables[EIA9_BIT_PPS])
			|=> s_reg.flags[EIA9_BIT_PPS];
	endproperty
	a_pps_flag: assert property (p_pps_flag) else $error("second pulse event lost");

	property p_read_flags;
		@(posedge clk_sys) disable iff (reset)
		(!avs_waitrequest && avs_read && avs_address == EIA9_IDX_FLAGS)
			|-> (avs_readdata[7:0] & ~EIA9_SRC_MASK) == 8'h00;
	endproperty
	a_read_flags: assert property (p_read_flags) else $error("unused flag bit read set");

	property p_reset_flags;
		@(posedge clk_sys) disable iff (reset)
		$past(reset) |-> s_reg.flags == EIA9_RST_FLAGS
			&& s_reg.overrun == EIA9_RST_OVERRUN;
	endproperty
	a_reset_flags: assert property (p_reset_flags) else $error("flags not clear after reset");

	property p_no_ovr;
		@(posedge clk_sys) disable iff (reset)
		(s_reg.overrun != 8'h00 && (s_reg.flags & s_reg.enables) == 8'h00)
			|=> !s_reg.core[EIA9_BIT_FLAG];
	endproperty
	a_no_ovr: assert property (p_no_ovr) else $error("pending bit raised request");

	property p_group_drop;
		@(posedge clk_sys) disable iff (reset)
		((s_reg.flags & s_reg.enables) == 8'h00) |=> !s_reg.core[EIA9_BIT_FLAG];
	endproperty
	a_group_drop: assert property (p_group_drop) else $error("group request stuck");

	property p_deliver;
		@(posedge clk_sys) disable iff (reset)
		(s_reg.core[EIA9_BIT_FLAG] && s_reg.core[EIA9_BIT_GLOBAL]
			&& s_reg.core[EIA9_BIT_EXTEN])
			|=> group9_irq;
	endproperty
	a_deliver: assert property (p_deliver) else $error("enabled request not taken");

	property p_gate_irq;
		@(posedge clk_sys) disable iff (reset)
		!s_reg.pctrl[EIA9_BIT_GATE] |-> ##2 !group9_irq;
	endproperty
	a_gate_irq: assert property (p_gate_irq) else $error("irq with gate off");

	property p_ovr_only;
		@(posedge clk_sys) disable iff (reset)
		$rose(s_reg.overrun[EIA9_BIT_TX])
			|-> $past(hw_set[EIA9_BIT_TX] && s_reg.flags[EIA9_BIT_TX]);
	endproperty
	a_ovr_only: assert property (p_ovr_only) else $error("pending set without overrun");

	property p_write_lands;
		@(posedge clk_sys) disable iff (reset)
		(wr_hit && avs_address == EIA9_IDX_ENABLES)
			|=> s_reg.enables == ($past(wbyte) & EIA9_SRC_MASK);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("enable write lost");

	property p_soft_blocked;
		@(posedge clk_sys) disable iff (reset)
		(wr_hit && avs_address == EIA9_IDX_FLAGS && !s_reg.enables[EIA9_BIT_PPS]
			&& !s_reg.flags[EIA9_BIT_PPS])
			|=> !s_reg.flags[EIA9_BIT_PPS];
	endproperty
	a_soft_blocked: assert property (p_soft_blocked) else $error("disabled flag set by write");

	property p_ans_once;
		@(posedge clk_sys) disable iff (reset)
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_ans_once: assert property (p_ans_once) else $error("answer held too long");

	property p_rdata_high;
		@(posedge clk_sys) disable iff (reset)
		!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
	endproperty
	a_rdata_high: assert property (p_rdata_high) else $error("upper read bits set");
endmodule : eia9_aggregator
